/* File: mir_regs.svh */
// offsets, field positions, reset values and timing counts of the access port
`ifndef MIR_REGS_SVH
`define MIR_REGS_SVH

// ****************************************************************
// special-function byte addresses
// ****************************************************************
`define MIR_SFR_POINTER      8'h91
`define MIR_SFR_DATA_LOW     8'h92
`define MIR_SFR_DATA_MID     8'h93
`define MIR_SFR_DATA_HIGH    8'h94
`define MIR_SFR_VRMS_LOW     8'hD1
`define MIR_SFR_VRMS_MID     8'hD2
`define MIR_SFR_VRMS_HIGH    8'hD3
`define MIR_SFR_IRMS_LOW     8'hD4
`define MIR_SFR_IRMS_MID     8'hD5
`define MIR_SFR_IRMS_HIGH    8'hD6
`define MIR_SFR_IRQEN_LOW    8'hD9
`define MIR_SFR_IRQEN_MID    8'hDA
`define MIR_SFR_IRQEN_HIGH   8'hDB
`define MIR_SFR_IRQST_LOW    8'hDC
`define MIR_SFR_IRQST_MID    8'hDD
`define MIR_SFR_IRQST_HIGH   8'hDE
`define MIR_SFR_WAV1_LOW     8'hE2
`define MIR_SFR_WAV1_MID     8'hE3
`define MIR_SFR_WAV1_HIGH    8'hE4
`define MIR_SFR_WAV2_LOW     8'hE5
`define MIR_SFR_WAV2_MID     8'hE6
`define MIR_SFR_WAV2_HIGH    8'hE7

// ****************************************************************
// pointer byte fields
// ****************************************************************
`define MIR_PTR_DIR_BIT      7
`define MIR_PTR_ADDR_MSB     6

// ****************************************************************
// internal register addresses
// ****************************************************************
`define MIR_IA_ACT_TOTAL     7'h01
`define MIR_IA_ACT_CLEAR     7'h02
`define MIR_IA_ACT_LINE      7'h03
`define MIR_IA_REA_TOTAL     7'h04
`define MIR_IA_REA_CLEAR     7'h05
`define MIR_IA_REA_LINE      7'h06
`define MIR_IA_APP_TOTAL     7'h07
`define MIR_IA_APP_CLEAR     7'h08
`define MIR_IA_APP_LINE      7'h09
`define MIR_IA_LINE_PERIOD_OR_FREQUENCY      7'h0A
`define MIR_IA_CONFIG2       7'h0C
`define MIR_IA_HALF_CYC      7'h12

// ****************************************************************
// reset values and config fields
// ****************************************************************
`define MIR_CONFIG2_RESET    8'h40
`define MIR_HALF_CYC_RESET   16'hFFFF
`define MIR_CFG2_FREQ_BIT    0
`define MIR_CFG2_RMS_BIT     1

// ****************************************************************
// timing
// ****************************************************************
`define MIR_REF_CLK_HZ       100000000
`define MIR_METER_CLK_HZ     819200
`define MIR_METER_DIV        (`MIR_REF_CLK_HZ / `MIR_METER_CLK_HZ)

`endif

/* File: mir_pkg.sv */
// types shared by the metering indirect access port
package mir_pkg;

	// ****************************************************************
	// transfer sequencer states
	// ****************************************************************
	typedef enum logic [1:0] {
		MIR_IDLE    = 2'b00,
		MIR_PENDING = 2'b01
	} mir_xfer_type;

	// ****************************************************************
	// processor special-function bus request
	// ****************************************************************
	typedef struct packed {
		logic [7:0] addr;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} mir_sfr_req_type;

	// ****************************************************************
	// measurement results from the metering datapath
	// ****************************************************************
	typedef struct packed {
		logic [23:0] active_delta;
		logic [23:0] reactive_delta;
		logic [23:0] apparent_delta;
		logic [23:0] rms_delta;
		logic        half_cycle;
		logic [15:0] line_period;
		logic [15:0] line_freq;
		logic [23:0] vrms;
		logic [23:0] irms;
		logic [23:0] wav1;
		logic [23:0] wav2;
		logic [23:0] irq_status;
	} mir_meter_in_type;

	// ****************************************************************
	// complete state of the port
	// ****************************************************************
	typedef struct packed {
		mir_xfer_type xfer;
		logic [7:0]   div_cnt;
		logic [7:0]   pointer;
		logic [7:0]   data_low;
		logic [7:0]   data_mid;
		logic [7:0]   data_high;
		logic [7:0]   rdata;
		logic         busy;
		logic [23:0]  irq_enable;
		logic [23:0]  irq_clear;
		logic [23:0]  vrms_latch;
		logic [23:0]  irms_latch;
		logic [23:0]  wav1_latch;
		logic [23:0]  wav2_latch;
		logic [23:0]  act_acc;
		logic [23:0]  rea_acc;
		logic [23:0]  app_acc;
		logic [23:0]  act_line_acc;
		logic [23:0]  rea_line_acc;
		logic [23:0]  app_line_acc;
		logic [23:0]  act_line;
		logic [23:0]  rea_line;
		logic [23:0]  app_line;
		logic [15:0]  half_cnt;
		logic [7:0]   config2;
		logic [15:0]  half_cycle_count;
	} mir_state_type;

endpackage : mir_pkg

/* File: mir_port.sv */
// indirect access port into the metering core's internal registers
`include "mir_regs.svh"

// Notes on behaviour
// R1 - pointer write starts access; bit 7 set means write, clear means read
// R2 - pointer bits 6..0 select the internal register address
// R3 - write transfer copies low, middle and high data bytes to the register
// R4 - one-byte register write takes only the low data byte
// R5 - read transfer loads the selected register into the data bytes
// R6 - one-byte register read updates low byte, zeroes middle and high
// R7 - transfers happen on the slower metering tick, not the processor clock
// R8 - software waits after an internal write before the next access
// R9 - software waits after an internal read before moving data bytes
// R10 - two-byte register: middle byte upper eight bits, low byte lower
// R11 - plain active energy read returns signed 24-bit value, no change
// R12 - read-with-clear addresses return value and zero that accumulator
// R13 - line-synchronous addresses return energy over whole half-cycles
// R14 - reactive energy offered at plain, clearing and line-sync addresses
// R15 - apparent accumulators gather current rms when select bit is set
// R16 - 16-bit register returns line period or frequency per config
// R17 - three-byte rms/waveform bytes latch all 24 bits on high-byte read
// R18 - interrupt status bytes captured individually when each is read
// R19 - line-sync half-cycle count comes from a 16-bit config register
// R20 - every transfer completes within one metering tick period
// R21 - unimplemented address reads zero, write has no effect
module mir_port #(
	parameter int METER_DIV = `MIR_METER_DIV
) (
	// clock and reset
	input  wire logic                  ref_clk,
	input  wire logic                  rstn,
	// processor special-function bus
	input  wire mir_pkg::mir_sfr_req_type sfr_req,
	output logic [7:0]                 sfr_rdata,
	// metering datapath
	input  wire mir_pkg::mir_meter_in_type meter_in,
	output logic                       xfer_busy,
	output logic [7:0]                 meter_config_second,
	output logic [15:0]                half_cycle_count,
	output logic [23:0]                meter_irq_enable,
	output logic [23:0]                meter_irq_clear
);

	// ****************************************************************
	// helpers
	// ****************************************************************
	// picks byte 0, 1 or 2 of a 24-bit value
	function automatic logic [7:0] pick_byte(input logic [23:0] v,
		input logic [1:0] idx);
		logic [7:0] r;
		r = 8'h00;
		case (idx)
			2'h0: r = v[7:0];
			2'h1: r = v[15:8];
			2'h2: r = v[23:16];
			default: r = 8'h00;
		endcase
		return r;
	endfunction : pick_byte

	// one-byte internal registers
	function automatic logic is_one_byte(input logic [6:0] a);
		return a == `MIR_IA_CONFIG2;
	endfunction : is_one_byte

	// ****************************************************************
	// state
	// ****************************************************************
	mir_pkg::mir_state_type st_ff;
	mir_pkg::mir_state_type nxt_st;
	logic                   tick;
	logic [6:0]             iaddr;
	logic [23:0]            ival;
	logic                   ihit;
	logic [23:0]            wval;
	logic [23:0]            app_inc;
	logic [15:0]            half_next;

	// ****************************************************************
	// next-state logic
	// ****************************************************************
	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.irq_clear = 24'h000000;
		iaddr = st_ff.pointer[`MIR_PTR_ADDR_MSB:0]; // R2
		ival = 24'h000000;
		ihit = 1'b0;
		wval = {st_ff.data_high, st_ff.data_mid, st_ff.data_low};
		half_next = st_ff.half_cnt;

		// metering rate as a one-cycle enable
		tick = 1'b0;
		if (st_ff.div_cnt == 8'(METER_DIV - 1))
		begin
			nxt_st.div_cnt = 8'h00;
			tick = 1'b1; // R7
		end
		else
		begin
			nxt_st.div_cnt = st_ff.div_cnt + 8'h01;
		end

		// internal register read mux
		if (iaddr == `MIR_IA_ACT_TOTAL || iaddr == `MIR_IA_ACT_CLEAR)
		begin
			ival = st_ff.act_acc; // R11
			ihit = 1'b1;
		end
		else if (iaddr == `MIR_IA_ACT_LINE)
		begin
			ival = st_ff.act_line; // R13
			ihit = 1'b1;
		end
		else if (iaddr == `MIR_IA_REA_TOTAL || iaddr == `MIR_IA_REA_CLEAR)
		begin
			ival = st_ff.rea_acc; // R14
			ihit = 1'b1;
		end
		else if (iaddr == `MIR_IA_REA_LINE)
		begin
			ival = st_ff.rea_line; // R14
			ihit = 1'b1;
		end
		else if (iaddr == `MIR_IA_APP_TOTAL || iaddr == `MIR_IA_APP_CLEAR)
		begin
			ival = st_ff.app_acc;
			ihit = 1'b1;
		end
		else if (iaddr == `MIR_IA_APP_LINE)
		begin
			ival = st_ff.app_line; // R13
			ihit = 1'b1;
		end
		else if (iaddr == `MIR_IA_LINE_PERIOD_OR_FREQUENCY)
		begin
			// R16
			ival = {8'h00, st_ff.config2[`MIR_CFG2_FREQ_BIT] ?
				meter_in.line_freq : meter_in.line_period};
			ihit = 1'b1;
		end
		else if (iaddr == `MIR_IA_CONFIG2)
		begin
			ival = {16'h0000, st_ff.config2};
			ihit = 1'b1;
		end
		else if (iaddr == `MIR_IA_HALF_CYC)
		begin
			ival = {8'h00, st_ff.half_cycle_count}; // R10
			ihit = 1'b1;
		end

		// transfer on the metering tick; one period at most
		case (st_ff.xfer)
			mir_pkg::MIR_IDLE:
			begin
				nxt_st.busy = 1'b0;
			end
			mir_pkg::MIR_PENDING:
			begin
				if (tick) // R20
				begin
					nxt_st.xfer = mir_pkg::MIR_IDLE;
					nxt_st.busy = 1'b0;
					if (st_ff.pointer[`MIR_PTR_DIR_BIT]) // R1
					begin
						// R3 R21 writes land only on writable registers
						if (iaddr == `MIR_IA_CONFIG2)
							nxt_st.config2 = st_ff.data_low; // R4
						else if (iaddr == `MIR_IA_HALF_CYC)
							nxt_st.half_cycle_count = wval[15:0]; // R10
					end
					else
					begin
						// R5 R21 unknown address loads zeros
						nxt_st.data_low = ival[7:0];
						nxt_st.data_mid = ival[15:8];
						nxt_st.data_high = ival[23:16];
						if (is_one_byte(iaddr))
						begin
							nxt_st.data_mid = 8'h00; // R6
							nxt_st.data_high = 8'h00; // R6
						end
						// R12 clear on read-with-reset addresses
						if (ihit && iaddr == `MIR_IA_ACT_CLEAR)
							nxt_st.act_acc = 24'h000000;
						if (ihit && iaddr == `MIR_IA_REA_CLEAR)
							nxt_st.rea_acc = 24'h000000;
						if (ihit && iaddr == `MIR_IA_APP_CLEAR)
							nxt_st.app_acc = 24'h000000;
					end
				end
			end
			default:
			begin
				nxt_st.xfer = mir_pkg::MIR_IDLE;
				nxt_st.busy = 1'b0;
			end
		endcase

		// processor writes; pointer last so it restarts a transfer
		if (sfr_req.wr)
		begin
			if (sfr_req.addr == `MIR_SFR_POINTER)
			begin
				nxt_st.pointer = sfr_req.wdata; // R1
				nxt_st.xfer = mir_pkg::MIR_PENDING;
				nxt_st.busy = 1'b1;
			end
			else if (sfr_req.addr == `MIR_SFR_DATA_LOW)
				nxt_st.data_low = sfr_req.wdata;
			else if (sfr_req.addr == `MIR_SFR_DATA_MID)
				nxt_st.data_mid = sfr_req.wdata;
			else if (sfr_req.addr == `MIR_SFR_DATA_HIGH)
				nxt_st.data_high = sfr_req.wdata;
			else if (sfr_req.addr == `MIR_SFR_IRQEN_LOW)
				nxt_st.irq_enable[7:0] = sfr_req.wdata;
			else if (sfr_req.addr == `MIR_SFR_IRQEN_MID)
				nxt_st.irq_enable[15:8] = sfr_req.wdata;
			else if (sfr_req.addr == `MIR_SFR_IRQEN_HIGH)
				nxt_st.irq_enable[23:16] = sfr_req.wdata;
			// zeros written to a status byte request those flags cleared
			else if (sfr_req.addr == `MIR_SFR_IRQST_LOW)
				nxt_st.irq_clear[7:0] = ~sfr_req.wdata;
			else if (sfr_req.addr == `MIR_SFR_IRQST_MID)
				nxt_st.irq_clear[15:8] = ~sfr_req.wdata;
			else if (sfr_req.addr == `MIR_SFR_IRQST_HIGH)
				nxt_st.irq_clear[23:16] = ~sfr_req.wdata;
		end

		// processor reads; answer one cycle later
		if (sfr_req.rd)
		begin
			nxt_st.rdata = 8'h00;
			if (sfr_req.addr == `MIR_SFR_POINTER)
				nxt_st.rdata = st_ff.pointer;
			else if (sfr_req.addr == `MIR_SFR_DATA_LOW)
				nxt_st.rdata = st_ff.data_low;
			else if (sfr_req.addr == `MIR_SFR_DATA_MID)
				nxt_st.rdata = st_ff.data_mid;
			else if (sfr_req.addr == `MIR_SFR_DATA_HIGH)
				nxt_st.rdata = st_ff.data_high;
			else if (sfr_req.addr == `MIR_SFR_VRMS_LOW)
				nxt_st.rdata = pick_byte(st_ff.vrms_latch, 2'h0); // R17
			else if (sfr_req.addr == `MIR_SFR_VRMS_MID)
				nxt_st.rdata = pick_byte(st_ff.vrms_latch, 2'h1); // R17
			else if (sfr_req.addr == `MIR_SFR_VRMS_HIGH)
			begin
				nxt_st.vrms_latch = meter_in.vrms; // R17
				nxt_st.rdata = pick_byte(meter_in.vrms, 2'h2);
			end
			else if (sfr_req.addr == `MIR_SFR_IRMS_LOW)
				nxt_st.rdata = pick_byte(st_ff.irms_latch, 2'h0); // R17
			else if (sfr_req.addr == `MIR_SFR_IRMS_MID)
				nxt_st.rdata = pick_byte(st_ff.irms_latch, 2'h1); // R17
			else if (sfr_req.addr == `MIR_SFR_IRMS_HIGH)
			begin
				nxt_st.irms_latch = meter_in.irms; // R17
				nxt_st.rdata = pick_byte(meter_in.irms, 2'h2);
			end
			else if (sfr_req.addr == `MIR_SFR_IRQEN_LOW)
				nxt_st.rdata = st_ff.irq_enable[7:0];
			else if (sfr_req.addr == `MIR_SFR_IRQEN_MID)
				nxt_st.rdata = st_ff.irq_enable[15:8];
			else if (sfr_req.addr == `MIR_SFR_IRQEN_HIGH)
				nxt_st.rdata = st_ff.irq_enable[23:16];
			// status sampled live, one byte per read
			else if (sfr_req.addr == `MIR_SFR_IRQST_LOW)
				nxt_st.rdata = pick_byte(meter_in.irq_status, 2'h0); // R18
			else if (sfr_req.addr == `MIR_SFR_IRQST_MID)
				nxt_st.rdata = pick_byte(meter_in.irq_status, 2'h1); // R18
			else if (sfr_req.addr == `MIR_SFR_IRQST_HIGH)
				nxt_st.rdata = pick_byte(meter_in.irq_status, 2'h2); // R18
			else if (sfr_req.addr == `MIR_SFR_WAV1_LOW)
				nxt_st.rdata = pick_byte(st_ff.wav1_latch, 2'h0); // R17
			else if (sfr_req.addr == `MIR_SFR_WAV1_MID)
				nxt_st.rdata = pick_byte(st_ff.wav1_latch, 2'h1); // R17
			else if (sfr_req.addr == `MIR_SFR_WAV1_HIGH)
			begin
				nxt_st.wav1_latch = meter_in.wav1; // R17
				nxt_st.rdata = pick_byte(meter_in.wav1, 2'h2);
			end
			else if (sfr_req.addr == `MIR_SFR_WAV2_LOW)
				nxt_st.rdata = pick_byte(st_ff.wav2_latch, 2'h0); // R17
			else if (sfr_req.addr == `MIR_SFR_WAV2_MID)
				nxt_st.rdata = pick_byte(st_ff.wav2_latch, 2'h1); // R17
			else if (sfr_req.addr == `MIR_SFR_WAV2_HIGH)
			begin
				nxt_st.wav2_latch = meter_in.wav2; // R17
				nxt_st.rdata = pick_byte(meter_in.wav2, 2'h2);
			end
		end

		// accumulate after any clear, so a tick's energy is never lost
		app_inc = st_ff.config2[`MIR_CFG2_RMS_BIT] ?
			meter_in.rms_delta : meter_in.apparent_delta; // R15
		if (tick)
		begin
			nxt_st.act_acc = nxt_st.act_acc + meter_in.active_delta;
			nxt_st.rea_acc = nxt_st.rea_acc + meter_in.reactive_delta;
			nxt_st.app_acc = nxt_st.app_acc + app_inc; // R15
			nxt_st.act_line_acc = st_ff.act_line_acc +
				meter_in.active_delta;
			nxt_st.rea_line_acc = st_ff.rea_line_acc +
				meter_in.reactive_delta;
			nxt_st.app_line_acc = st_ff.app_line_acc + app_inc;
		end

		// line-synchronous window closes after the set half-cycles
		if (meter_in.half_cycle)
		begin
			half_next = st_ff.half_cnt + 16'h0001;
			if (half_next >= st_ff.half_cycle_count) // R19
			begin
				nxt_st.act_line = nxt_st.act_line_acc; // R13
				nxt_st.rea_line = nxt_st.rea_line_acc; // R13
				nxt_st.app_line = nxt_st.app_line_acc; // R13
				nxt_st.act_line_acc = 24'h000000;
				nxt_st.rea_line_acc = 24'h000000;
				nxt_st.app_line_acc = 24'h000000;
				nxt_st.half_cnt = 16'h0000;
			end
			else
			begin
				nxt_st.half_cnt = half_next;
			end
		end
	end

	// ****************************************************************
	// state register
	// ****************************************************************
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			st_ff <= '0;
			st_ff.xfer <= mir_pkg::MIR_IDLE;
			st_ff.config2 <= `MIR_CONFIG2_RESET;
			st_ff.half_cycle_count <= `MIR_HALF_CYC_RESET;
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

	// outputs straight from the state register
	assign sfr_rdata = st_ff.rdata;
	assign xfer_busy = st_ff.busy;
	assign meter_config_second = st_ff.config2;
	assign half_cycle_count = st_ff.half_cycle_count;
	assign meter_irq_enable = st_ff.irq_enable;
	assign meter_irq_clear = st_ff.irq_clear;

endmodule : mir_port

/* File: mir_port_props.sv */
// port-level checker for the metering indirect access port
`include "mir_regs.svh"

module mir_port_props #(
	parameter int METER_DIV = 4
) (
	// clock and reset
	input wire logic                      ref_clk,
	input wire logic                      rstn,
	// processor special-function bus
	input wire mir_pkg::mir_sfr_req_type  sfr_req,
	input wire logic [7:0]                sfr_rdata,
	// metering datapath
	input wire mir_pkg::mir_meter_in_type meter_in,
	input wire logic                      xfer_busy,
	input wire logic [7:0]                meter_config_second,
	input wire logic [15:0]               half_cycle_count,
	input wire logic [23:0]               meter_irq_enable,
	input wire logic [23:0]               meter_irq_clear
);
	timeunit 1ns;
	timeprecision 100ps;

	// a pointer write that just misses a tick waits METER_DIV cycles; the extra cycle is margin
	localparam int BUSY_MAX = METER_DIV + 1;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	// ****************************************************************
	// transfer sequencing
	// ****************************************************************
	property p_busy_rise;
		sfr_req.wr && sfr_req.addr == `MIR_SFR_POINTER |=> xfer_busy;
	endproperty
	a_busy_rise: assert property (p_busy_rise)
		else $error("busy not raised after pointer write");
	property p_busy_cause;
		$rose(xfer_busy) |-> $past(sfr_req.wr)
			&& $past(sfr_req.addr) == `MIR_SFR_POINTER;
	endproperty
	a_busy_cause: assert property (p_busy_cause)
		else $error("busy raised without pointer write");
	property p_busy_bound;
		$rose(xfer_busy) |-> ##[1:BUSY_MAX] !xfer_busy;
	endproperty
	a_busy_bound: assert property (p_busy_bound)
		else $error("transfer not finished in time");
	property p_cfg_quiet;
		!xfer_busy |=> $stable(meter_config_second)
			&& $stable(half_cycle_count);
	endproperty
	a_cfg_quiet: assert property (p_cfg_quiet)
		else $error("internal register changed outside a transfer");

	// ****************************************************************
	// direct byte reads and writes
	// ****************************************************************
	property p_vrms_high;
		sfr_req.rd && sfr_req.addr == `MIR_SFR_VRMS_HIGH
			|=> sfr_rdata == $past(meter_in.vrms[23:16]);
	endproperty
	a_vrms_high: assert property (p_vrms_high)
		else $error("high rms byte not taken at read");
	property p_rdata_hold;
		!sfr_req.rd |=> $stable(sfr_rdata);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold)
		else $error("read data moved without a read");
	property p_status_live;
		sfr_req.rd && sfr_req.addr == `MIR_SFR_IRQST_LOW
			|=> sfr_rdata == $past(meter_in.irq_status[7:0]);
	endproperty
	a_status_live: assert property (p_status_live)
		else $error("status byte not captured at read");
	property p_status_clear;
		sfr_req.wr && sfr_req.addr == `MIR_SFR_IRQST_LOW
			|=> meter_irq_clear == {16'h0000, ~$past(sfr_req.wdata)};
	endproperty
	a_status_clear: assert property (p_status_clear)
		else $error("status clear pulse wrong");
	property p_unmapped;
		sfr_req.rd && sfr_req.addr < `MIR_SFR_POINTER |=> sfr_rdata == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped byte read not zero");

	c_xfer: cover property ($fell(xfer_busy));
	c_clear: cover property (meter_irq_clear != 24'h000000);
	c_latch: cover property (sfr_req.rd && sfr_req.addr == `MIR_SFR_WAV2_HIGH);
endmodule : mir_port_props

bind mir_port mir_port_props #(.METER_DIV(METER_DIV)) u_props (
	.ref_clk(ref_clk), .rstn(rstn), .sfr_req(sfr_req),
	.sfr_rdata(sfr_rdata), .meter_in(meter_in), .xfer_busy(xfer_busy),
	.meter_config_second(meter_config_second),
	.half_cycle_count(half_cycle_count),
	.meter_irq_enable(meter_irq_enable), .meter_irq_clear(meter_irq_clear)
);

/* File: mir_meter_model.sv */
// metering datapath model feeding the access port
module mir_meter_model #(
	parameter logic [23:0] DELTA = 24'h000001
) (
	// clock
	input  wire logic                 ref_clk,
	// bench control
	input  wire logic                 run,
	input  wire logic                 half,
	// measurement levels
	output mir_pkg::mir_meter_in_type meter_in
);
	timeunit 1ns;
	timeprecision 100ps;

	// one process drives every level, so the struct has a single driver;
	// fixed measurements are distinct per byte so lane slips show;
	// deltas flow only while run is high: a run of whole tick
	// periods then holds an exact number of ticks whatever the phase
	always @(negedge ref_clk)
	begin
		meter_in.line_period <= 16'h1388;
		meter_in.line_freq <= 16'h0032;
		meter_in.vrms <= 24'h123456;
		meter_in.irms <= 24'h789ABC;
		meter_in.wav1 <= 24'hDEF012;
		meter_in.wav2 <= 24'h345678;
		meter_in.irq_status <= 24'hA5C33C;
		meter_in.active_delta <= run ? DELTA : 24'h000000;
		meter_in.reactive_delta <= run ? DELTA << 1 : 24'h000000;
		meter_in.apparent_delta <= run ? DELTA * 24'h000003 : 24'h000000;
		meter_in.rms_delta <= run ? DELTA << 2 : 24'h000000;
		meter_in.half_cycle <= half;
	end
endmodule : mir_meter_model

/* File: tb.sv */
// self-checking bench for the metering indirect access port
`include "mir_regs.svh"

module tb;
	timeunit 1ns;
	timeprecision 100ps;

	localparam int DIV = 4;
	localparam logic [23:0] D = 24'h000111;
	localparam logic [7:0] BASE [4] = '{8'hD1, 8'hD4, 8'hE2, 8'hE5};

	logic                      ref_clk;
	logic                      rstn;
	logic                      run;
	logic                      half;
	mir_pkg::mir_sfr_req_type  req;
	mir_pkg::mir_meter_in_type mi;
	logic [7:0]                rdata;
	logic [7:0]                cfg;
	logic [15:0]               hcc;
	logic                      busy;
	logic [23:0]               irq_en;
	logic [23:0]               irq_clr;
	logic [23:0]               v;
	logic [23:0]               wv [4];
	logic [7:0]                l;
	logic [7:0]                m;
	logic [7:0]                h;
	int                        fails;
	int                        n_tests;
	int                        i;

	mir_port #(.METER_DIV(DIV)) dut (
		.ref_clk(ref_clk), .rstn(rstn), .sfr_req(req), .sfr_rdata(rdata),
		.meter_in(mi), .xfer_busy(busy), .meter_config_second(cfg),
		.half_cycle_count(hcc), .meter_irq_enable(irq_en),
		.meter_irq_clear(irq_clr)
	);
	mir_meter_model #(.DELTA(D)) u_meter (
		.ref_clk(ref_clk), .run(run), .half(half), .meter_in(mi)
	);

	// ****************************************************************
	// bus tasks
	// ****************************************************************
	task chk(input logic [23:0] got, input logic [23:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			fails++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// strobes rise and fall on falling edges, one idle cycle between
	task sfr_wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
		@(negedge ref_clk);
		req.wr = 1'b0;
	endtask : sfr_wr

	task sfr_rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge ref_clk);
		req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
		@(negedge ref_clk);
		req.rd = 1'b0;
		d = rdata;
	endtask : sfr_rd

	task ind(input logic [7:0] p);
		int k;
		sfr_wr(`MIR_SFR_POINTER, p);
		chk({23'h0, busy}, 24'h000001);
		for (k = 0; k < 4 * DIV && busy === 1'b1; k++)
			@(negedge ref_clk);
		chk({23'h0, busy}, 24'h000000);
	endtask : ind

	task wr_ind(input logic [6:0] a, input logic [23:0] d);
		sfr_wr(`MIR_SFR_DATA_LOW, d[7:0]);
		sfr_wr(`MIR_SFR_DATA_MID, d[15:8]);
		sfr_wr(`MIR_SFR_DATA_HIGH, d[23:16]);
		ind({1'b1, a});
	endtask : wr_ind

	task rd_ind(input logic [6:0] a, input logic [23:0] e);
		ind({1'b0, a});
		sfr_rd(`MIR_SFR_DATA_LOW, l);
		sfr_rd(`MIR_SFR_DATA_MID, m);
		sfr_rd(`MIR_SFR_DATA_HIGH, h);
		chk({h, m, l}, e);
	endtask : rd_ind

	// one line half-cycle pulse, then let it settle
	task pulse_half;
		half <= 1'b1;
		@(negedge ref_clk);
		half <= 1'b0;
		repeat (3) @(negedge ref_clk);
	endtask : pulse_half

	task test_done;
		$display("tests %0d failures %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : test_done

	// ****************************************************************
	// clock, watchdog and tests
	// ****************************************************************
	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// the whole run needs well under a thousand cycles
	initial
	begin
		#100000;
		fails++;
		test_done;
	end

	initial
	begin
		fails = 0;
		n_tests = 0;
		rstn = 1'b0;
		run = 1'b0;
		half = 1'b0;
		req = '0;
		repeat (4) @(negedge ref_clk);
		rstn = 1'b1;
		chk({16'h0000, cfg}, 24'h000040);
		chk({8'h00, hcc}, 24'h00FFFF);
		wr_ind(`MIR_IA_HALF_CYC, 24'hAB1234);
		chk({8'h00, hcc}, 24'h001234);
		rd_ind(`MIR_IA_HALF_CYC, 24'h001234);
		wr_ind(`MIR_IA_CONFIG2, 24'hBBAA03);
		chk({16'h0000, cfg}, 24'h000003);
		rd_ind(`MIR_IA_CONFIG2, 24'h000003);
		rd_ind(`MIR_IA_LINE_PERIOD_OR_FREQUENCY, {8'h00, mi.line_freq});
		wr_ind(`MIR_IA_CONFIG2, 24'h000002);
		rd_ind(`MIR_IA_LINE_PERIOD_OR_FREQUENCY, {8'h00, mi.line_period});
		wr_ind(`MIR_IA_HALF_CYC, 24'h000002);
		// exactly two tick periods of energy
		run <= 1'b1;
		repeat (2 * DIV) @(negedge ref_clk);
		run <= 1'b0;
		repeat (2) @(negedge ref_clk);
		// active, reactive, then apparent gathering rms
		for (i = 0; i < 3; i++)
		begin
			v = D << (i + 1);
			rd_ind(7'(3 * i + 1), v);
			rd_ind(7'(3 * i + 1), v);
			rd_ind(7'(3 * i + 2), v);
			rd_ind(7'(3 * i + 1), 24'h000000);
		end
		pulse_half;
		rd_ind(`MIR_IA_ACT_LINE, 24'h000000);
		pulse_half;
		for (i = 0; i < 3; i++)
			rd_ind(7'(3 * i + 3), D << (i + 1));
		rd_ind(7'h7F, 24'h000000);
		wr_ind(7'h7F, 24'h0000FF);
		chk({16'h0000, cfg}, 24'h000002);
		chk({8'h00, hcc}, 24'h000002);
		// low byte is stale until the high byte latches
		wv = '{mi.vrms, mi.irms, mi.wav1, mi.wav2};
		for (i = 0; i < 4; i++)
		begin
			sfr_rd(BASE[i], l);
			chk({16'h0000, l}, 24'h000000);
			sfr_rd(BASE[i] + 8'h02, h);
			sfr_rd(BASE[i] + 8'h01, m);
			sfr_rd(BASE[i], l);
			chk({h, m, l}, wv[i]);
		end
		for (i = 0; i < 3; i++)
		begin
			sfr_wr(`MIR_SFR_IRQEN_LOW + 8'(i), 8'h11 * 8'(i + 1));
			sfr_rd(`MIR_SFR_IRQST_LOW + 8'(i), l);
			chk({16'h0000, l}, {16'h0000, mi.irq_status[8 * i +: 8]});
			sfr_wr(`MIR_SFR_IRQST_LOW + 8'(i), 8'hF0);
			chk(irq_clr, 24'h00000F << (8 * i));
		end
		chk(irq_en, 24'h332211);
		sfr_rd(8'h80, l);
		chk({16'h0000, l}, 24'h000000);
		// mid-run reset brings back the defaults and empties line regs
		@(negedge ref_clk);
		rstn = 1'b0;
		repeat (2) @(negedge ref_clk);
		rstn = 1'b1;
		chk({16'h0000, cfg}, 24'h000040);
		chk({8'h00, hcc}, 24'h00FFFF);
		chk(irq_en, 24'h000000);
		rd_ind(`MIR_IA_ACT_LINE, 24'h000000);
		test_done;
	end
endmodule : tb
